// >>> rtl/synch_check.sv
// Generator synch-check supervision with slow-close failure detection
// Contract
// - Slip equals generator frequency minus system frequency.
// - Slip is good only between low and high slip limits.
// - Offset phase by -30, 0 or +30 degree compensation angle.
// - All three angle flags need voltage, difference and slip supervision.
// - Uncompensated angle is absolute generator-system phase difference.
// - Compensated angle adds slip angle swept in breaker close time.
// - Uncompensated flag while uncompensated angle below its limit.
// - Compensated flag while compensated angle below its limit.
// - Close-initiate flag when compensated angle equals target close angle.
// - Close-failure detector arms when device initiates a close.
// - Detector disarms when breaker-open indication deasserts.
// - Armed, breaker open, angle beyond fail angle: assert close-failed.
// - Armed detector disarms itself after 99 seconds; here the timeout is held off while close-failed is latched.
// - Close-fail angle Off never asserts close-failed.
// - Block input at one blocks the function; zero operates.
// - Either voltage outside low/high window fails voltage supervision.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module synch_check #(
    parameter logic [31:0] disarm_count = synch_pkg::disarm_cycles
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire synch_pkg::meas_t meas,
    input wire logic meas_valid,
    input wire logic synch_block_ctl,
    input wire logic breaker_open_ind,
    input wire logic close_cmd,
    output synch_pkg::perm_t perm,
    output logic close_failed_flag,
    output logic irq
);
    // Configuration registers
    logic [31:0] ctrl_q;
    logic [31:0] slip_lim_q;
    logic [31:0] volt_lim_q;
    logic [15:0] uncomp_angle_limit_q;
    logic [15:0] comp_angle_limit_q;
    logic [15:0] target_close_angle_q;
    logic [15:0] breaker_close_time_q;
    logic [15:0] close_fail_angle_q;
    logic [15:0] vdiff_lim_q;
    logic [synch_pkg::ev_count-1:0] irq_stat_q;
    logic [synch_pkg::ev_count-1:0] irq_mask_q;
    logic [synch_pkg::ev_count-1:0] events;
    logic [synch_pkg::ev_count-1:0] flags_prev_q;
    logic [synch_pkg::ev_count-1:0] flags_now;
    // Detector state
    logic armed_q;
    logic [31:0] disarm_cnt_q;
    // Datapath
    logic slip_ok;
    logic volt_ok;
    logic vdiff_ok;
    logic superv_ok;
    logic signed [15:0] slip;
    logic signed [15:0] xfmr_comp_angle;
    logic signed [15:0] slip_low_limit;
    logic signed [15:0] slip_high_limit;
    logic [15:0] volt_low_limit;
    logic [15:0] volt_high_limit;
    logic signed [17:0] raw_diff;
    logic signed [17:0] wrap_diff;
    logic [15:0] uncomp_angle;
    logic signed [31:0] close_time_s;
    logic signed [31:0] swept_wide;
    logic signed [17:0] swept;
    logic signed [17:0] comp_signed;
    logic signed [17:0] comp_wrap;
    logic [15:0] comp_angle;
    logic [15:0] vdiff;
    logic [31:0] status_word;
    logic wr;
    logic rd;

    // APB strobes; zero wait states
    // Ready tied high: each access takes one cycle
    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign pready = 1'b1;

    // Field views of the configuration words
    assign slip_low_limit = slip_lim_q[15:0];
    assign slip_high_limit = slip_lim_q[31:16];
    assign volt_low_limit = volt_lim_q[15:0];
    assign volt_high_limit = volt_lim_q[31:16];

    // Slip in mHz, positive when generator runs fast
    assign slip = meas.gen_freq - meas.sys_freq;

    // Lower limit below upper is software's duty; check is inclusive
    assign slip_ok = (slip >= slip_low_limit) &&
                     (slip <= slip_high_limit);

    // Both voltages must sit inside the magnitude window
    // Limits are inclusive at both ends
    assign volt_ok = (meas.gen_volt >= volt_low_limit) &&
                     (meas.gen_volt <= volt_high_limit) &&
                     (meas.sys_volt >= volt_low_limit) &&
                     (meas.sys_volt <= volt_high_limit);

    // Absolute voltage difference; a zero limit disables the check
    assign vdiff = (meas.gen_volt >= meas.sys_volt) ?
                   (meas.gen_volt - meas.sys_volt) :
                   (meas.sys_volt - meas.gen_volt);
    assign vdiff_ok = (vdiff_lim_q == 16'h0000) ||
                      (vdiff <= vdiff_lim_q);

    // Block input gates all three angle flags
    // Blocked flags fall at the next taken sample
    assign superv_ok = slip_ok && volt_ok && vdiff_ok &&
                       !synch_block_ctl;

    // Transformer phase shift selection
    // Code 3 is unused and means no shift
    always_comb
    begin
        unique case (ctrl_q[2:1])
            synch_pkg::comp_minus30: xfmr_comp_angle = -synch_pkg::deg30;
            synch_pkg::comp_plus30: xfmr_comp_angle = synch_pkg::deg30;
            default: xfmr_comp_angle = 16'sh0000;
        endcase
    end

    // Compensation cancels the transformer shift: a negative setting
    // means the system side leads, so it is taken off the difference
    assign raw_diff = 18'(meas.gen_angle) - 18'(meas.sys_angle) -
                      18'(xfmr_comp_angle);
    always_comb
    begin
        wrap_diff = raw_diff;
        if (raw_diff > 18'(synch_pkg::deg180))
            wrap_diff = raw_diff - 18'(synch_pkg::deg360);
        else if (raw_diff < -18'(synch_pkg::deg180))
            wrap_diff = raw_diff + 18'(synch_pkg::deg360);
    end
    // Wrapped value is within half a turn and fits 16 bits
    assign uncomp_angle = wrap_diff[17] ? 16'(-wrap_diff) :
                          16'(wrap_diff);

    // Close time zero-extended into a signed word, so that a negative
    // slip keeps its sign through the product
    assign close_time_s = $signed({16'h0000, breaker_close_time_q});
    // Swept angle: slip(mHz)*time(ms)*3600/1e6 in 0.1 deg units
    // Truncation errs by under 0.1 degree, fine for the windows
    // Product stays in 32 bits for close times up to about 1.8 s
    assign swept_wide = (32'(slip) * close_time_s * 32'sd36)
                        / 32'sd10000;
    assign swept = 18'(swept_wide);
    // Prediction: angle advances with slip over the close time
    assign comp_signed = wrap_diff + swept;
    always_comb
    begin
        comp_wrap = comp_signed;
        if (comp_signed > 18'(synch_pkg::deg180))
            comp_wrap = comp_signed - 18'(synch_pkg::deg360);
        else if (comp_signed < -18'(synch_pkg::deg180))
            comp_wrap = comp_signed + 18'(synch_pkg::deg360);
    end
    // Magnitude of the predicted angle at contact touch
    assign comp_angle = comp_wrap[17] ? 16'(-comp_wrap) : 16'(comp_wrap);

    // Permission flags registered on each valid sample
    // Flags hold between samples
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            perm <= '0;
        else if (meas_valid)
        begin
            perm.uncomp_angle_ok <= superv_ok &&
                (uncomp_angle < uncomp_angle_limit_q);
            perm.comp_angle_ok <= superv_ok &&
                (comp_angle < comp_angle_limit_q);
            perm.close_initiate_pulse <= superv_ok &&
                (comp_angle == target_close_angle_q);
        end
    end

    // Slow-close detector; timeout parameter lets benches shorten 99 s
    // A latched failure blocks the timeout so the lockout stays
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            armed_q <= 1'b0;
            disarm_cnt_q <= 32'h0000_0000;
        end
        else if (close_cmd && perm.close_initiate_pulse)
        begin
            armed_q <= 1'b1;
            disarm_cnt_q <= 32'h0000_0000;
        end
        else if (armed_q)
        begin
            if (!breaker_open_ind)
                armed_q <= 1'b0;
            else if (!close_failed_flag &&
                     disarm_cnt_q >= disarm_count - 32'h0000_0001)
                armed_q <= 1'b0;
            else
                disarm_cnt_q <= disarm_cnt_q + 32'h0000_0001;
        end
    end

    // Close failure latches while armed; clears once disarmed
    // Off setting wins, so no stale latch lingers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            close_failed_flag <= 1'b0;
        else if (close_fail_angle_q == synch_pkg::cf_off)
            close_failed_flag <= 1'b0;
        else if (armed_q && breaker_open_ind &&
                 uncomp_angle > close_fail_angle_q)
            close_failed_flag <= 1'b1;
        else if (!armed_q)
            close_failed_flag <= 1'b0;
    end

    // Rising edges of flags become sticky interrupt events
    // A standing flag gives one event, not a stream
    assign flags_now = {close_failed_flag, perm.close_initiate_pulse,
                        perm.comp_angle_ok, perm.uncomp_angle_ok};
    assign events = flags_now & ~flags_prev_q;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flags_prev_q <= '0;
        else
            flags_prev_q <= flags_now;
    end

    // Write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_stat_q <= '0;
        else if (wr && paddr == synch_pkg::irq_stat_off)
            irq_stat_q <= (irq_stat_q & ~pwdata[synch_pkg::ev_count-1:0])
                          | events;
        else
            irq_stat_q <= irq_stat_q | events;
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // Configuration register writes
    // Unmapped and read-only offsets are ignored
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= synch_pkg::ctrl_rst;
            slip_lim_q <= synch_pkg::slip_lim_rst;
            volt_lim_q <= synch_pkg::volt_lim_rst;
            uncomp_angle_limit_q <= synch_pkg::ang_lim_rst;
            comp_angle_limit_q <= synch_pkg::ang_lim_rst;
            target_close_angle_q <= 16'h0000;
            breaker_close_time_q <= synch_pkg::close_time_rst;
            close_fail_angle_q <= synch_pkg::cf_angle_rst;
            vdiff_lim_q <= synch_pkg::vdiff_rst;
            irq_mask_q <= '0;
        end
        else if (wr)
        begin
            unique case (paddr)
                synch_pkg::ctrl_off: ctrl_q <= {29'h0, pwdata[2:1], 1'b0};
                synch_pkg::slip_lim_off: slip_lim_q <= pwdata;
                synch_pkg::volt_lim_off: volt_lim_q <= pwdata;
                synch_pkg::uncomp_lim_off:
                    uncomp_angle_limit_q <= pwdata[15:0];
                synch_pkg::comp_lim_off: comp_angle_limit_q <= pwdata[15:0];
                synch_pkg::target_off: target_close_angle_q <= pwdata[15:0];
                synch_pkg::close_time_off:
                    breaker_close_time_q <= pwdata[15:0];
                synch_pkg::cf_angle_off: close_fail_angle_q <= pwdata[15:0];
                synch_pkg::vdiff_off: vdiff_lim_q <= pwdata[15:0];
                synch_pkg::irq_mask_off:
                    irq_mask_q <= pwdata[synch_pkg::ev_count-1:0];
                default: ;
            endcase
        end
    end

    // Live status view; read-only, so writes to it are refused
    assign status_word = {26'h0, armed_q, close_failed_flag, superv_ok,
                          perm};

    // Read data registered in the setup cycle, valid in access
    // Loading early keeps the access phase free of a decode path
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (rd)
            begin
                unique case (paddr)
                    synch_pkg::ctrl_off: prdata <= ctrl_q;
                    synch_pkg::slip_lim_off: prdata <= slip_lim_q;
                    synch_pkg::volt_lim_off: prdata <= volt_lim_q;
                    synch_pkg::uncomp_lim_off:
                        prdata <= {16'h0, uncomp_angle_limit_q};
                    synch_pkg::comp_lim_off:
                        prdata <= {16'h0, comp_angle_limit_q};
                    synch_pkg::target_off:
                        prdata <= {16'h0, target_close_angle_q};
                    synch_pkg::close_time_off:
                        prdata <= {16'h0, breaker_close_time_q};
                    synch_pkg::cf_angle_off:
                        prdata <= {16'h0, close_fail_angle_q};
                    synch_pkg::vdiff_off: prdata <= {16'h0, vdiff_lim_q};
                    synch_pkg::status_off: prdata <= status_word;
                    synch_pkg::irq_stat_off: prdata <= {28'h0, irq_stat_q};
                    synch_pkg::irq_mask_off: prdata <= {28'h0, irq_mask_q};
                    default: pslverr <= 1'b1;
                endcase
            end
            else if (!(paddr inside {synch_pkg::ctrl_off,
                     synch_pkg::slip_lim_off, synch_pkg::volt_lim_off,
                     synch_pkg::uncomp_lim_off, synch_pkg::comp_lim_off,
                     synch_pkg::target_off, synch_pkg::close_time_off,
                     synch_pkg::cf_angle_off, synch_pkg::vdiff_off,
                     synch_pkg::irq_stat_off, synch_pkg::irq_mask_off}))
                pslverr <= 1'b1;
        end
        else
            pslverr <= 1'b0; // Error shows in the access phase only
    end
endmodule // synch_check

// >>> inc/synch_pkg.sv
// Package of constants and types for the synch-check block
package synch_pkg;
    // APB register byte offsets
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] slip_lim_off = 8'h04;
    localparam logic [7:0] volt_lim_off = 8'h08;
    localparam logic [7:0] uncomp_lim_off = 8'h0c;
    localparam logic [7:0] comp_lim_off = 8'h10;
    localparam logic [7:0] target_off = 8'h14;
    localparam logic [7:0] close_time_off = 8'h18;
    localparam logic [7:0] cf_angle_off = 8'h1c;
    localparam logic [7:0] status_off = 8'h20;
    localparam logic [7:0] irq_stat_off = 8'h24;
    localparam logic [7:0] irq_mask_off = 8'h28;
    localparam logic [7:0] vdiff_off = 8'h2c;
    // Transformer compensation codes (ctrl bits 2:1)
    localparam logic [1:0] comp_zero = 2'h0;
    localparam logic [1:0] comp_minus30 = 2'h1;
    localparam logic [1:0] comp_plus30 = 2'h2;
    // Angles in units of 0.1 degree, signed 16 bit
    localparam logic signed [15:0] deg30 = 16'sh012c;
    localparam logic signed [15:0] deg180 = 16'sh0708;
    localparam logic signed [15:0] deg360 = 16'sh0e10;
    // Close-failure angle value meaning Off
    localparam logic [15:0] cf_off = 16'h0000;
    // Reset values
    localparam logic [31:0] ctrl_rst = 32'h0000_0000;
    localparam logic [31:0] slip_lim_rst = 32'h0019_0005;
    localparam logic [31:0] volt_lim_rst = 32'h02be_025b;
    localparam logic [15:0] ang_lim_rst = 16'h0064;
    localparam logic [15:0] close_time_rst = 16'h0096;
    localparam logic [15:0] cf_angle_rst = 16'h012c;
    localparam logic [15:0] vdiff_rst = 16'h0000;
    // Disarm timeout: 99 s at 40 MHz
    localparam int unsigned clk_hz = 40_000_000;
    localparam int unsigned disarm_s = 99;
    localparam longint unsigned disarm_cycles_l =
        longint'(disarm_s) * longint'(clk_hz);
    localparam logic [31:0] disarm_cycles = disarm_cycles_l[31:0];
    // Event bits of the interrupt status
    localparam int ev_uncomp = 0;
    localparam int ev_comp = 1;
    localparam int ev_close = 2;
    localparam int ev_cfail = 3;
    localparam int ev_count = 4;
    // Measured quantities from the phasor front end
    typedef struct packed {
        logic signed [15:0] gen_angle;  // 0.1 degree
        logic signed [15:0] sys_angle;  // 0.1 degree
        logic [15:0] gen_volt;          // 0.1 V
        logic [15:0] sys_volt;          // 0.1 V
        logic signed [15:0] gen_freq;   // mHz
        logic signed [15:0] sys_freq;   // mHz
    } meas_t;
    // Angle permission flags
    typedef struct packed {
        logic close_initiate_pulse;
        logic comp_angle_ok;
        logic uncomp_angle_ok;
    } perm_t;
endpackage

// >>> tb/synch_check_chk.sv
// Port-level timing checker for the synch-check block
`timescale 1ns/1ps
module synch_check_chk #(
    parameter logic [31:0] disarm_count = 32'h0000_00c8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic meas_valid,
    input wire logic synch_block_ctl,
    input wire logic breaker_open_ind,
    input wire synch_pkg::perm_t perm,
    input wire logic close_failed_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Breaker seen closed on two samples in a row
    sequence s_closed2;
        !breaker_open_ind ##1 !breaker_open_ind;
    endsequence
    // Read setup to a place past the map
    sequence s_bad_setup;
        psel && !penable && !pwrite && paddr > 8'h2c;
    endsequence
    property p_block;
        meas_valid && synch_block_ctl |=> perm == 3'h0;
    endproperty
    a_block: assert property (p_block)
        else $error("angle flag set while blocked");
    // Flags only move on a taken sample
    property p_hold;
        !meas_valid |=> $stable(perm);
    endproperty
    a_hold: assert property (p_hold)
        else $error("angle flags moved without a sample");
    property p_cf_open;
        $rose(close_failed_flag) |-> $past(breaker_open_ind);
    endproperty
    a_cf_open: assert property (p_cf_open)
        else $error("close failure raised with breaker closed");
    property p_cf_clear;
        s_closed2 |=> !close_failed_flag;
    endproperty
    a_cf_clear: assert property (p_cf_clear)
        else $error("close failure kept after breaker closed");
    // Timeout must not drop a failure already raised
    property p_cf_stay;
        close_failed_flag && breaker_open_ind |=> close_failed_flag;
    endproperty
    a_cf_stay: assert property (p_cf_stay)
        else $error("close failure dropped while breaker open");
    property p_err_access;
        pslverr |-> psel && penable;
    endproperty
    a_err_access: assert property (p_err_access)
        else $error("slave error outside access phase");
    property p_rd_stable;
        psel && penable |=> $stable(prdata);
    endproperty
    a_rd_stable: assert property (p_rd_stable)
        else $error("read data changed after access");
    property p_unmapped;
        s_bad_setup |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
    property p_ready;
        pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready low");
endmodule // synch_check_chk

bind synch_check synch_check_chk #(.disarm_count(disarm_count)) chk_u (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_valid(meas_valid),
    .synch_block_ctl(synch_block_ctl), .breaker_open_ind(breaker_open_ind),
    .perm(perm), .close_failed_flag(close_failed_flag));

// >>> tb/breaker_model.sv
// Generator breaker and bus lockout relay model
`timescale 1ns/1ps
module breaker_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic close_cmd,
    input wire logic close_failed_flag,
    input wire logic stuck,
    input wire logic reopen,
    output logic breaker_open_ind,
    output logic lockout_trip
);
    logic cmd_q;
    logic [1:0] dly_q;
    // Mechanism travels 3 cycles; a stuck one never gets there
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_q <= 1'b0;
            dly_q <= 2'h0;
            breaker_open_ind <= 1'b1;
        end
        else if (reopen)
        begin
            cmd_q <= 1'b0;
            dly_q <= 2'h0;
            breaker_open_ind <= 1'b1;
        end
        else
        begin
            cmd_q <= cmd_q | close_cmd;
            if (cmd_q && !stuck && dly_q != 2'h3)
                dly_q <= dly_q + 2'h1;
            if (dly_q == 2'h3)
                breaker_open_ind <= 1'b0;
        end
    end
    // Lockout latches; only reset frees the bus again
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            lockout_trip <= 1'b0;
        else
            lockout_trip <= lockout_trip | close_failed_flag;
    end
endmodule // breaker_model

// >>> tb/synch_check_tb.sv
// Testbench of the synch-check block
`timescale 1ns/1ps
module synch_check_tb;
    typedef struct packed {
        logic [31:0] ctl;
        logic [15:0] ga;
        logic [15:0] sa;
        logic [15:0] gf;
        logic [15:0] gv;
        logic blk;
        logic [2:0] ex;
    } row_t;
    logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, meas_valid = 1'b0, synch_block_ctl = 1'b0;
    logic close_cmd = 1'b0, stuck = 1'b1, reopen = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, breaker_open_ind;
    logic close_failed_flag, irq, lockout_trip;
    synch_pkg::meas_t meas = '0;
    synch_pkg::perm_t perm;
    int err_count = 0;
    int checks_done = 0;
    row_t rows [11];
    logic [7:0] rst_a [6];
    logic [31:0] rst_v [6];
    synch_check #(.disarm_count(32'h0000_00c8)) dut_u (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas(meas),
        .meas_valid(meas_valid), .synch_block_ctl(synch_block_ctl),
        .breaker_open_ind(breaker_open_ind), .close_cmd(close_cmd),
        .perm(perm), .close_failed_flag(close_failed_flag), .irq(irq));
    breaker_model brk_u (.clk(clk), .reset_n(reset_n), .close_cmd(close_cmd),
        .close_failed_flag(close_failed_flag), .stuck(stuck),
        .reopen(reopen), .breaker_open_ind(breaker_open_ind),
        .lockout_trip(lockout_trip));
    initial
        forever #12.5 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One APB transfer; ready is waited for, never assumed
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_count++;
            complete_run();
        end
        else
        begin
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Present one measurement; flags register on the same edge that takes it
    task automatic sample(input row_t r);
        @(posedge clk);
        meas.gen_angle <= r.ga;
        meas.sys_angle <= r.sa;
        meas.gen_freq <= r.gf;
        meas.gen_volt <= r.gv;
        synch_block_ctl <= r.blk;
        meas_valid <= 1'b1;
        @(posedge clk);
        meas_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // Close issued while the close-initiate flag stands
    task automatic arm;
        sample(rows[2]);
        @(posedge clk);
        close_cmd <= 1'b1;
        @(posedge clk);
        close_cmd <= 1'b0;
    endtask
    initial
    begin
        meas.sys_volt = 16'h029e;
        meas.sys_freq = 16'h03e8;
        // Slip 20 mHz, 250 ms close time: compensation adds 1.8 deg
        rows = '{'{32'h0, 16'h28, 16'h0, 16'h3fc, 16'h29e, 1'b0, 3'h3},
            '{32'h0, 16'h5a, 16'h0, 16'h3fc, 16'h29e, 1'b0, 3'h1},
            '{32'h0, 16'h20, 16'h0, 16'h3fc, 16'h29e, 1'b0, 3'h7},
            '{32'h0, 16'h6d6, 16'hf92a, 16'h3fc, 16'h29e, 1'b0, 3'h2},
            '{32'h2, 16'hfeac, 16'h0, 16'h3fc, 16'h29e, 1'b0, 3'h3},
            '{32'h4, 16'h154, 16'h0, 16'h3fc, 16'h29e, 1'b0, 3'h3},
            '{32'h0, 16'h20, 16'h0, 16'h3fc, 16'h29e, 1'b1, 3'h0},
            '{32'h0, 16'h28, 16'h0, 16'h3fc, 16'h258, 1'b0, 3'h0},
            '{32'h0, 16'h28, 16'h0, 16'h3d4, 16'h29e, 1'b0, 3'h0},
            '{32'h0, 16'h190, 16'h0, 16'h3fc, 16'h29e, 1'b0, 3'h0},
            '{32'h0, 16'h28, 16'h0, 16'h3fc, 16'h2be, 1'b0, 3'h0}};
        rst_a = '{synch_pkg::slip_lim_off, synch_pkg::volt_lim_off,
            synch_pkg::uncomp_lim_off, synch_pkg::cf_angle_off,
            synch_pkg::irq_mask_off, 8'h30};
        rst_v = '{synch_pkg::slip_lim_rst, synch_pkg::volt_lim_rst,
            32'h64, 32'h12c, 32'h0, 32'h0};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rst_a[i])
        begin
            apb(1'b0, rst_a[i], 32'h0);
            check(rdat, rst_v[i]);
        end
        check({31'h0, rerr}, 32'h1);
        $display("test reset values done");
        apb(1'b1, synch_pkg::close_time_off, 32'hfa);
        apb(1'b1, synch_pkg::target_off, 32'h32);
        apb(1'b1, synch_pkg::vdiff_off, 32'h10);
        foreach (rows[i])
        begin
            apb(1'b1, synch_pkg::ctrl_off, rows[i].ctl);
            sample(rows[i]);
            check(32'(perm[0]), 32'(rows[i].ex[0]));
            check(32'(perm[1]), 32'(rows[i].ex[1]));
            check(32'(perm[2]), 32'(rows[i].ex[2]));
        end
        $display("test angle windows done");
        apb(1'b0, synch_pkg::irq_stat_off, 32'h0);
        check(rdat, 32'h7);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, synch_pkg::irq_mask_off, 32'hf);
        #1;
        check({31'h0, irq}, 32'h1);
        apb(1'b1, synch_pkg::irq_stat_off, 32'h7);
        #1;
        check({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        arm();
        sample(rows[9]);
        @(posedge clk);
        #1;
        check({31'h0, close_failed_flag}, 32'h1);
        check({31'h0, lockout_trip}, 32'h1);
        @(posedge clk);
        stuck <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check({31'h0, close_failed_flag}, 32'h0);
        $display("test close failure done");
        @(posedge clk);
        reopen <= 1'b1;
        stuck <= 1'b1;
        @(posedge clk);
        reopen <= 1'b0;
        arm();
        apb(1'b0, synch_pkg::status_off, 32'h0);
        check(rdat, 32'h2f);
        repeat (210) @(posedge clk);
        apb(1'b0, synch_pkg::status_off, 32'h0);
        check(rdat, 32'h0f);
        sample(rows[9]);
        @(posedge clk);
        #1;
        check({31'h0, close_failed_flag}, 32'h0);
        $display("test disarm timeout done");
        apb(1'b1, synch_pkg::cf_angle_off, 32'h0);
        arm();
        sample(rows[9]);
        @(posedge clk);
        #1;
        check({31'h0, close_failed_flag}, 32'h0);
        apb(1'b0, synch_pkg::irq_stat_off, 32'h0);
        check(rdat, 32'hf);
        check({31'h0, irq}, 32'h1);
        $display("test failure off done");
        complete_run();
    end
endmodule // synch_check_tb
